// ---- ccs_params.svh ----
`ifndef CCS_PARAMS_SVH
`define CCS_PARAMS_SVH

// ==========================================================
// link framing
`define CCS_SLAVE_ADDR      7'h69
`define CCS_BYTE_BITS       4'h8
`define CCS_PTR_W           5

// ==========================================================
// register map and reset values
`define CCS_REG_FREQ_SEL    5'h04
`define CCS_REG_CLK_CTRL    5'h05
`define CCS_FREQ_SEL_RST    8'h00
`define CCS_CLK_CTRL_RST    8'hCE
`define CCS_UNMAPPED_READ   8'h00

// ==========================================================
// frequency select fields
`define CCS_FS_TRI_BIT      0
`define CCS_FS_IDX5_BIT     1
`define CCS_FS_IDX4_BIT     2
`define CCS_FS_SRC_BIT      3
`define CCS_FS_IDX_HI       7
`define CCS_FS_IDX_LO       4

// ==========================================================
// clock control fields
`define CCS_CC_CPU1T_BIT    1
`define CCS_CC_CPU0T_BIT    2
`define CCS_CC_CPU0C_BIT    3
`define CCS_CC_WIDE_BIT     4
`define CCS_CC_SPREAD_BIT   5
`define CCS_CC_CENTER_BIT   6

// ==========================================================
// table entry fields
`define CCS_TE_VCO_HI       35
`define CCS_TE_VCO_LO       20
`define CCS_TE_CPU_HI       19
`define CCS_TE_CPU_LO       16
`define CCS_TE_SDR_HI       15
`define CCS_TE_SDR_LO       12
`define CCS_TE_PCI_HI       11
`define CCS_TE_PCI_LO       8
`define CCS_TE_AGP0_HI      7
`define CCS_TE_AGP0_LO      4
`define CCS_TE_AGP1_HI      3
`define CCS_TE_AGP1_LO      0

// ==========================================================
// strap capture
`define CCS_STRAP_WAIT      2'h2
`define CCS_HW_IDX_PAD      2'h0

`endif

// ---- ccs_pkg.sv ----
package ccs_pkg;

    typedef enum logic [5:0] {
        LS_IDLE  = 6'h01,
        LS_ADDR  = 6'h02,
        LS_CMD   = 6'h04,
        LS_CNT   = 6'h08,
        LS_WDATA = 6'h10,
        LS_RDATA = 6'h20
    } ccs_link_state_e;

    typedef logic [35:0] ccs_entry_t;

endpackage : ccs_pkg

// ---- ccs_bus_if.sv ----
interface ccs_bus_if;
    logic       wr_tgl;
    logic [4:0] wr_idx;
    logic [7:0] wr_data;
    logic [4:0] rd_idx;
    logic [7:0] rd_data;
    logic       start_tgl;
    logic       stop_tgl;

    modport link (
        output wr_tgl,
        output wr_idx,
        output wr_data,
        output rd_idx,
        input  rd_data,
        output start_tgl,
        output stop_tgl
    );

    modport core (
        input  wr_tgl,
        input  wr_idx,
        input  wr_data,
        input  rd_idx,
        output rd_data,
        input  start_tgl,
        input  stop_tgl
    );
endinterface : ccs_bus_if

// ---- ccs_link.sv ----
`include "ccs_params.svh"

module ccs_link import ccs_pkg::*; (
    input  wire logic ctrl_clock_line,
    input  wire logic ctrl_data_in,
    input  wire logic rst_n,
    output logic      data_oe_ff,
    ccs_bus_if.link   bus
);

    // ==========================================================
    // start and stop detection on data edges
    logic                  start_tgl_ff;
    logic                  stop_tgl_ff;
    logic                  start_seen_ff;
    ccs_link_state_e       state_ff;
    logic [3:0]            cnt_ff;
    logic [7:0]            shift_ff;
    logic [`CCS_PTR_W-1:0] ptr_ff;
    logic                  wr_tgl_ff;
    logic [`CCS_PTR_W-1:0] wr_idx_ff;
    logic [7:0]            wr_data_ff;
    logic [7:0]            rd_byte_ff;

    always_ff @(negedge ctrl_data_in or negedge rst_n) begin
        if (!rst_n) begin
            start_tgl_ff <= 1'b0;
        end else if (ctrl_clock_line) begin
            start_tgl_ff <= ~start_tgl_ff;
        end
    end

    always_ff @(posedge ctrl_data_in or negedge rst_n) begin
        if (!rst_n) begin
            stop_tgl_ff <= 1'b0;
        end else if (ctrl_clock_line) begin
            stop_tgl_ff <= ~stop_tgl_ff;
        end
    end

    // ==========================================================
    // bit sampling on rising clock
    always_ff @(posedge ctrl_clock_line or negedge rst_n) begin
        if (!rst_n) begin
            start_seen_ff <= 1'b0;
            state_ff      <= LS_IDLE;
            cnt_ff        <= 4'h0;
            shift_ff      <= 8'h00;
            ptr_ff        <= '0;
            wr_tgl_ff     <= 1'b0;
            wr_idx_ff     <= '0;
            wr_data_ff    <= 8'h00;
        end else if (start_tgl_ff != start_seen_ff) begin
            start_seen_ff <= start_tgl_ff;
            state_ff      <= LS_ADDR;
            cnt_ff        <= 4'h1;
            shift_ff      <= {7'h00, ctrl_data_in};
        end else if (state_ff != LS_IDLE) begin
            if (cnt_ff != `CCS_BYTE_BITS) begin
                shift_ff <= {shift_ff[6:0], ctrl_data_in};
                cnt_ff   <= cnt_ff + 4'h1;
            end else begin
                cnt_ff <= 4'h0;
                case (state_ff)
                    LS_ADDR: begin
                        ptr_ff <= '0;
                        if (shift_ff[7:1] != `CCS_SLAVE_ADDR) begin
                            state_ff <= LS_IDLE;
                        end else if (shift_ff[0]) begin
                            state_ff <= LS_RDATA;
                        end else begin
                            state_ff <= LS_CMD;
                        end
                    end
                    LS_CMD: begin
                        state_ff <= LS_CNT;
                    end
                    LS_CNT: begin
                        state_ff <= LS_WDATA;
                    end
                    LS_WDATA: begin
                        wr_idx_ff  <= ptr_ff;
                        wr_data_ff <= shift_ff;
                        wr_tgl_ff  <= ~wr_tgl_ff;
                        ptr_ff     <= ptr_ff + 1'b1;
                    end
                    LS_RDATA: begin
                        if (ctrl_data_in) begin
                            state_ff <= LS_IDLE;
                        end else begin
                            ptr_ff <= ptr_ff + 1'b1;
                        end
                    end
                    default: begin
                        state_ff <= LS_IDLE;
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // data drive on falling clock
    always_ff @(negedge ctrl_clock_line or negedge rst_n) begin
        if (!rst_n) begin
            data_oe_ff <= 1'b0;
            rd_byte_ff <= 8'h00;
        end else if (state_ff == LS_RDATA && cnt_ff == 4'h0) begin
            rd_byte_ff <= bus.rd_data;
            data_oe_ff <= ~bus.rd_data[7];
        end else if (state_ff == LS_RDATA && cnt_ff != `CCS_BYTE_BITS) begin
            data_oe_ff <= ~rd_byte_ff[3'h7 - cnt_ff[2:0]];
        end else if (cnt_ff == `CCS_BYTE_BITS &&
                     ((state_ff == LS_ADDR &&
                       shift_ff[7:1] == `CCS_SLAVE_ADDR) ||
                      state_ff == LS_CMD || state_ff == LS_CNT ||
                      state_ff == LS_WDATA)) begin
            data_oe_ff <= 1'b1;
        end else begin
            data_oe_ff <= 1'b0;
        end
    end

    assign bus.wr_tgl    = wr_tgl_ff;
    assign bus.wr_idx    = wr_idx_ff;
    assign bus.wr_data   = wr_data_ff;
    assign bus.rd_idx    = ptr_ff;
    assign bus.start_tgl = start_tgl_ff;
    assign bus.stop_tgl  = stop_tgl_ff;

endmodule : ccs_link

// ---- ccs_clock_synth_ctrl.sv ----
`include "ccs_params.svh"

module ccs_clock_synth_ctrl import ccs_pkg::*; (
    input  wire logic core_clk,
    input  wire logic reset_n,
    input  wire logic ctrl_clock_line,
    input  wire logic ctrl_data_line_in,
    output logic      ctrl_data_line_out,
    output logic      ctrl_data_line_oe,
    input  wire logic [3:0] strap_freq_select,
    output logic [5:0]  freq_index,
    output logic        freq_from_software,
    output logic [15:0] vco_freq_100khz,
    output logic [3:0]  cpu_ratio,
    output logic [3:0]  sdram_ratio,
    output logic [3:0]  pci_ratio,
    output logic [3:0]  agp0_ratio,
    output logic [3:0]  agp1_ratio,
    output logic        outputs_tristate,
    output logic        spread_center,
    output logic        spread_enable,
    output logic        spread_wide,
    output logic        cpu0_clock_comp_en,
    output logic        cpu0_clock_true_en,
    output logic        cpu1_clock_true_en,
    output logic        link_frame_active
);

    // ==========================================================
    // frequency table: vco in 100 kHz, then five ratios
    localparam ccs_entry_t FREQ_TABLE [0:63] = '{
        36'h0F9C66268,
        36'h0FA044368,
        36'h13743358A,
        36'h0F9633468,
        36'h0F9C64268,
        36'h0FA046368,
        36'h0FA043368,
        36'h0F9634468,
        36'h0D2033356,
        36'h0E8833468,
        36'h102C33468,
        36'h0BB822556,
        36'h0F9C63268,
        36'h13744348A,
        36'h0BB823556,
        36'h12C03458A,
        36'h106864268,
        36'h10E064268,
        36'h0D0443368,
        36'h0F2843368,
        36'h0FF043368,
        36'h104043368,
        36'h106843368,
        36'h10B843368,
        36'h101846368,
        36'h106846368,
        36'h109044368,
        36'h10B844368,
        36'h101844368,
        36'h106844368,
        36'h109044368,
        36'h10E044368,
        36'h0F3C33468,
        36'h0FD233468,
        36'h0FF033468,
        36'h104A33468,
        36'h106833468,
        36'h10A433468,
        36'h10C233468,
        36'h10FE33468,
        36'h0F3C33568,
        36'h0FD233568,
        36'h102C33568,
        36'h10A433568,
        36'h100E33568,
        36'h104A33568,
        36'h108633568,
        36'h10A433568,
        36'h0F3C34468,
        36'h0F783448A,
        36'h0FF03448A,
        36'h100E3448A,
        36'h102C3448A,
        36'h10A43448A,
        36'h10E03448A,
        36'h111C3448A,
        36'h11943458A,
        36'h11EE3458A,
        36'h12483458A,
        36'h131A3458A,
        36'h13743458A,
        36'h14823458A,
        36'h14DC3458A,
        36'h15723458A
    };

    // ==========================================================
    // reset release
    logic [1:0] rst_pipe_ff;
    logic       rst_n;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_pipe_ff <= 2'h0;
        end else begin
            rst_pipe_ff <= {rst_pipe_ff[0], 1'b1};
        end
    end

    assign rst_n = rst_pipe_ff[1];

    // ==========================================================
    // link engine on the serial clock
    ccs_bus_if bus ();
    logic      data_oe;

    ccs_link u_link (
        .ctrl_clock_line (ctrl_clock_line),
        .ctrl_data_in    (ctrl_data_line_in),
        .rst_n           (rst_n),
        .data_oe_ff      (data_oe),
        .bus             (bus.link)
    );

    assign ctrl_data_line_oe = data_oe;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_data_line_out <= 1'b0;
        end else begin
            ctrl_data_line_out <= 1'b0;
        end
    end

    // ==========================================================
    // toggle crossings: write, start, stop
    logic [2:0] tgl_s1_ff;
    logic [2:0] tgl_s2_ff;
    logic [2:0] tgl_s3_ff;
    logic [2:0] tgl_evt;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tgl_s1_ff <= 3'h0;
            tgl_s2_ff <= 3'h0;
            tgl_s3_ff <= 3'h0;
        end else begin
            tgl_s1_ff <= {bus.stop_tgl, bus.start_tgl, bus.wr_tgl};
            tgl_s2_ff <= tgl_s1_ff;
            tgl_s3_ff <= tgl_s2_ff;
        end
    end

    assign tgl_evt = tgl_s2_ff ^ tgl_s3_ff;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            link_frame_active <= 1'b0;
        end else if (tgl_evt[1]) begin
            link_frame_active <= 1'b1;
        end else if (tgl_evt[2]) begin
            link_frame_active <= 1'b0;
        end
    end

    // ==========================================================
    // strap capture once after power-up
    logic [3:0] strap_s1_ff;
    logic [3:0] strap_s2_ff;
    logic [3:0] strap_latched_ff;
    logic [1:0] strap_wait_ff;
    logic       strap_done_ff;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            strap_s1_ff <= 4'h0;
            strap_s2_ff <= 4'h0;
        end else begin
            strap_s1_ff <= strap_freq_select;
            strap_s2_ff <= strap_s1_ff;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            strap_wait_ff    <= 2'h0;
            strap_done_ff    <= 1'b0;
            strap_latched_ff <= 4'h0;
        end else if (!strap_done_ff) begin
            if (strap_wait_ff == `CCS_STRAP_WAIT) begin
                strap_latched_ff <= strap_s2_ff;
                strap_done_ff    <= 1'b1;
            end else begin
                strap_wait_ff <= strap_wait_ff + 2'h1;
            end
        end
    end

    // ==========================================================
    // control registers
    logic [7:0] freq_sel_ff;
    logic [7:0] clk_ctrl_ff;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            freq_sel_ff <= `CCS_FREQ_SEL_RST;
            clk_ctrl_ff <= `CCS_CLK_CTRL_RST;
        end else if (tgl_evt[0]) begin
            if (bus.wr_idx == `CCS_REG_FREQ_SEL) begin
                freq_sel_ff <= bus.wr_data;
            end else if (bus.wr_idx == `CCS_REG_CLK_CTRL) begin
                clk_ctrl_ff <= bus.wr_data;
            end
        end
    end

    // ==========================================================
    // read-back mux, static between writes
    always_comb begin
        if (bus.rd_idx == `CCS_REG_FREQ_SEL) begin
            bus.rd_data = freq_sel_ff;
        end else if (bus.rd_idx == `CCS_REG_CLK_CTRL) begin
            bus.rd_data = clk_ctrl_ff;
        end else begin
            bus.rd_data = `CCS_UNMAPPED_READ;
        end
    end

    // ==========================================================
    // frequency index selection
    logic [5:0] nxt_freq_index;
    ccs_entry_t entry;

    always_comb begin
        if (freq_sel_ff[`CCS_FS_SRC_BIT]) begin
            nxt_freq_index = {freq_sel_ff[`CCS_FS_IDX5_BIT],
                              freq_sel_ff[`CCS_FS_IDX4_BIT],
                              freq_sel_ff[`CCS_FS_IDX_HI:`CCS_FS_IDX_LO]};
        end else begin
            nxt_freq_index = {`CCS_HW_IDX_PAD, strap_latched_ff};
        end
    end

    assign entry = FREQ_TABLE[nxt_freq_index];

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            freq_index         <= 6'h00;
            freq_from_software <= 1'b0;
        end else begin
            freq_index         <= nxt_freq_index;
            freq_from_software <= freq_sel_ff[`CCS_FS_SRC_BIT];
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            vco_freq_100khz <= 16'h0000;
            cpu_ratio       <= 4'h0;
            sdram_ratio     <= 4'h0;
            pci_ratio       <= 4'h0;
            agp0_ratio      <= 4'h0;
            agp1_ratio      <= 4'h0;
        end else begin
            vco_freq_100khz <= entry[`CCS_TE_VCO_HI:`CCS_TE_VCO_LO];
            cpu_ratio       <= entry[`CCS_TE_CPU_HI:`CCS_TE_CPU_LO];
            sdram_ratio     <= entry[`CCS_TE_SDR_HI:`CCS_TE_SDR_LO];
            pci_ratio       <= entry[`CCS_TE_PCI_HI:`CCS_TE_PCI_LO];
            agp0_ratio      <= entry[`CCS_TE_AGP0_HI:`CCS_TE_AGP0_LO];
            agp1_ratio      <= entry[`CCS_TE_AGP1_HI:`CCS_TE_AGP1_LO];
        end
    end

    // ==========================================================
    // spread and output enables
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            outputs_tristate   <= 1'b0;
            spread_center      <= 1'b1;
            spread_enable      <= 1'b0;
            spread_wide        <= 1'b0;
        end else begin
            outputs_tristate   <= freq_sel_ff[`CCS_FS_TRI_BIT];
            spread_center      <= clk_ctrl_ff[`CCS_CC_CENTER_BIT];
            spread_enable      <= clk_ctrl_ff[`CCS_CC_SPREAD_BIT];
            spread_wide        <= clk_ctrl_ff[`CCS_CC_WIDE_BIT];
        end
    end

    // ==========================================================
    // cpu output enables
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cpu0_clock_comp_en <= 1'b1;
            cpu0_clock_true_en <= 1'b1;
            cpu1_clock_true_en <= 1'b1;
        end else begin
            cpu0_clock_comp_en <= clk_ctrl_ff[`CCS_CC_CPU0C_BIT];
            cpu0_clock_true_en <= clk_ctrl_ff[`CCS_CC_CPU0T_BIT];
            cpu1_clock_true_en <= clk_ctrl_ff[`CCS_CC_CPU1T_BIT];
        end
    end

endmodule : ccs_clock_synth_ctrl

// ---- ccs_ctrl_properties.sv ----
module ccs_ctrl_properties (
    input wire logic        core_clk,
    input wire logic        reset_n,
    input wire logic        ctrl_clock_line,
    input wire logic        ctrl_data_line_in,
    input wire logic        ctrl_data_line_out,
    input wire logic        ctrl_data_line_oe,
    input wire logic [3:0]  strap_freq_select,
    input wire logic [5:0]  freq_index,
    input wire logic        freq_from_software,
    input wire logic [15:0] vco_freq_100khz,
    input wire logic [3:0]  cpu_ratio,
    input wire logic [3:0]  sdram_ratio,
    input wire logic [3:0]  pci_ratio,
    input wire logic [3:0]  agp0_ratio,
    input wire logic [3:0]  agp1_ratio,
    input wire logic        outputs_tristate,
    input wire logic        spread_center,
    input wire logic        spread_enable,
    input wire logic        spread_wide,
    input wire logic        cpu0_clock_comp_en,
    input wire logic        cpu0_clock_true_en,
    input wire logic        cpu1_clock_true_en,
    input wire logic        link_frame_active
);
    // ==========================================================
    // settle counter after reset
    logic [3:0] settle_ff;
    logic       settled;
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            settle_ff <= 4'h0;
        end else if (settle_ff != 4'hF) begin
            settle_ff <= settle_ff + 4'h1;
        end
    end
    assign settled = (settle_ff == 4'hF);

    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    // ==========================================================
    // sequences
    sequence idx_held(logic [5:0] v);
        (settled && freq_index == v) [*3];
    endsequence
    sequence hw_mode;
        (settled && !freq_from_software) [*3];
    endsequence

    // ==========================================================
    // assertions
    entry_zero_a: assert property (idx_held(6'h00) |->
        vco_freq_100khz == 16'h0F9C && {cpu_ratio, sdram_ratio, pci_ratio,
        agp0_ratio, agp1_ratio} == 20'h66268)
        else $error("entry zero wrong");
    entry_top_a: assert property (idx_held(6'h3F) |->
        vco_freq_100khz == 16'h1572 && {cpu_ratio, sdram_ratio, pci_ratio,
        agp0_ratio, agp1_ratio} == 20'h3458A)
        else $error("entry 63 wrong");
    hw_index_a: assert property (hw_mode |->
        freq_index == {2'h0, strap_freq_select})
        else $error("hardware index not straps");
    out_low_a: assert property (ctrl_data_line_oe |->
        !ctrl_data_line_out)
        else $error("data driven high");
    ack_frame_a: assert property ($rose(ctrl_data_line_oe) |->
        link_frame_active)
        else $error("data pulled outside frame");
    oe_low_a: assert property ($changed(ctrl_data_line_oe) |->
        !ctrl_clock_line)
        else $error("data changed while clock high");
    cfg_frame_a: assert property ($changed({outputs_tristate,
        freq_from_software, spread_center, spread_enable, spread_wide,
        cpu0_clock_comp_en, cpu0_clock_true_en, cpu1_clock_true_en})
        |-> link_frame_active)
        else $error("config changed outside frame");
    start_cond_a: assert property ($rose(link_frame_active) |->
        ctrl_clock_line && !ctrl_data_line_in)
        else $error("frame without start");
endmodule : ccs_ctrl_properties

bind ccs_clock_synth_ctrl ccs_ctrl_properties u_props (
    .core_clk, .reset_n, .ctrl_clock_line, .ctrl_data_line_in,
    .ctrl_data_line_out, .ctrl_data_line_oe, .strap_freq_select,
    .freq_index, .freq_from_software, .vco_freq_100khz, .cpu_ratio,
    .sdram_ratio, .pci_ratio, .agp0_ratio, .agp1_ratio, .outputs_tristate,
    .spread_center, .spread_enable, .spread_wide, .cpu0_clock_comp_en,
    .cpu0_clock_true_en, .cpu1_clock_true_en, .link_frame_active
);

// ---- ccs_i2c_master.sv ----
module ccs_i2c_master (
    output logic      scl,
    output logic      sda_pull,
    input  wire logic sda
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        scl      = 1'b1;
        sda_pull = 1'b0;
    end

    // ==========================================================
    // framing, clock stands high between frames
    task start_c();
        #40;
        sda_pull = 1'b1;
        #80;
        scl = 1'b0;
        #40;
    endtask : start_c

    task stop_c();
        sda_pull = 1'b1;
        #40;
        scl = 1'b1;
        #80;
        sda_pull = 1'b0;
        #80;
    endtask : stop_c

    // ==========================================================
    // one bit, data moved only while clock low
    task bit_c(input logic b, output logic seen);
        sda_pull = ~b;
        #40;
        scl = 1'b1;
        #40;
        seen = sda;
        #40;
        scl = 1'b0;
        #40;
    endtask : bit_c

    // msb first, ack slot only after a whole byte
    task send_bits(input logic [7:0] b, input int n, output logic ack);
        logic s;
        ack = 1'b0;
        for (int i = 7; i > 7 - n; i--) begin
            bit_c(b[i], s);
        end
        if (n == 8) begin
            bit_c(1'b1, s);
            ack = ~s;
        end
    endtask : send_bits

    // ack each byte, nack the last
    task recv_byte(input logic last, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_c(1'b1, s);
            b[i] = s;
        end
        bit_c(last, s);
    endtask : recv_byte
endmodule : ccs_i2c_master

// ---- ccs_clock_synth_ctrl_bench.sv ----
module ccs_clock_synth_ctrl_bench;
    timeunit 1ns;
    timeprecision 100ps;

    localparam logic [3:0] STRAP = 4'hB;

    logic        core_clk = 1'b0;
    logic        reset_n  = 1'b0;
    logic [3:0]  strap    = STRAP;
    logic        scl;
    logic        m_pull;
    logic        sda;
    logic        dev_out;
    logic        dev_oe;
    logic [5:0]  freq_index;
    logic        freq_from_software;
    logic [15:0] vco_freq_100khz;
    logic [3:0]  cpu_ratio;
    logic [3:0]  sdram_ratio;
    logic [3:0]  pci_ratio;
    logic [3:0]  agp0_ratio;
    logic [3:0]  agp1_ratio;
    logic        outputs_tristate;
    logic        spread_center;
    logic        spread_enable;
    logic        spread_wide;
    logic        c0c_en;
    logic        c0t_en;
    logic        c1t_en;
    logic        frame_act;
    int          err_count = 0;
    int          n_checks  = 0;

    // rows: frequency select, clock control, vco, five ratios
    logic [51:0] rows [5] = '{52'hFE20157234_58A, 52'h2B5E0FF033468,
        52'h2C740D0443368, 52'h088A0F9C66268, 52'h00CE0BB822556};

    // pulled-up open-drain data wire
    assign sda = ~(m_pull | (dev_oe & ~dev_out));

    ccs_i2c_master m (.scl(scl), .sda_pull(m_pull), .sda(sda));

    ccs_clock_synth_ctrl uut (
        .core_clk(core_clk), .reset_n(reset_n), .ctrl_clock_line(scl),
        .ctrl_data_line_in(sda), .ctrl_data_line_out(dev_out),
        .ctrl_data_line_oe(dev_oe), .strap_freq_select(strap),
        .freq_index(freq_index), .freq_from_software(freq_from_software),
        .vco_freq_100khz(vco_freq_100khz), .cpu_ratio(cpu_ratio),
        .sdram_ratio(sdram_ratio), .pci_ratio(pci_ratio),
        .agp0_ratio(agp0_ratio), .agp1_ratio(agp1_ratio),
        .outputs_tristate(outputs_tristate), .spread_center(spread_center),
        .spread_enable(spread_enable), .spread_wide(spread_wide),
        .cpu0_clock_comp_en(c0c_en), .cpu0_clock_true_en(c0t_en),
        .cpu1_clock_true_en(c1t_en), .link_frame_active(frame_act)
    );

    // ==========================================================
    // clock, reset, watchdog
    initial begin
        forever #2 core_clk = ~core_clk;
    end
    initial begin
        repeat (16) @(posedge core_clk);
        reset_n <= 1'b1;
    end
    initial begin
        repeat (90000) @(posedge core_clk);
        err_count++;
        report_and_stop();
    end

    // ==========================================================
    // helpers
    task automatic chk(input string name, input logic [19:0] exp, got);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic wr_regs(input logic [7:0] addr, fs, cc,
                           input logic exp_ack, input int n_fs);
        logic       ack;
        logic [7:0] fr [8];
        fr = '{addr, 8'h00, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00, fs};
        m.start_c();
        for (int i = 0; i < 8; i++) begin
            m.send_bits(fr[i], (i == 7) ? n_fs : 8, ack);
            if (i < 7 || n_fs == 8) chk("write ack", exp_ack, ack);
        end
        if (n_fs == 8) begin
            m.send_bits(cc, 8, ack);
            chk("ctrl ack", exp_ack, ack);
            m.send_bits(8'hFF, 8, ack);
            chk("spare ack", exp_ack, ack);
        end
        m.stop_c();
    endtask : wr_regs

    task automatic rd_regs(input logic [7:0] fs, cc);
        logic       ack;
        logic [7:0] b;
        m.start_c();
        chk("frame active", 1'b1, frame_act);
        m.send_bits(8'hD3, 8, ack);
        chk("read ack", 1'b1, ack);
        for (int i = 0; i < 7; i++) begin
            m.recv_byte(i == 6, b);
            chk("read byte", (i == 4) ? fs : (i == 5) ? cc : 8'h00, b);
        end
        m.stop_c();
        chk("frame ended", 1'b0, frame_act);
    endtask : rd_regs

    task automatic chk_cfg(input logic [51:0] row);
        logic [7:0] fs;
        logic [7:0] cc;
        fs = row[51:44];
        cc = row[43:36];
        chk("index", fs[3] ? {fs[1], fs[2], fs[7:4]} : {2'h0, STRAP},
            freq_index);
        chk("source", fs[3], freq_from_software);
        chk("tristate", fs[0], outputs_tristate);
        chk("vco", row[35:20], vco_freq_100khz);
        chk("ratios", row[19:0], {cpu_ratio, sdram_ratio, pci_ratio,
            agp0_ratio, agp1_ratio});
        chk("control", cc[6:1], {spread_center, spread_enable, spread_wide,
            c0c_en, c0t_en, c1t_en});
    endtask : chk_cfg

    // ==========================================================
    // scenarios
    task automatic test_defaults();
        chk_cfg(rows[4]);
        rd_regs(8'h00, 8'hCE);
    endtask : test_defaults

    task automatic test_table();
        for (int i = 0; i < 5; i++) begin
            wr_regs(8'hD2, rows[i][51:44], rows[i][43:36], 1'b1, 8);
            chk_cfg(rows[i]);
            rd_regs(rows[i][51:44], rows[i][43:36]);
        end
    endtask : test_table

    task automatic test_bad_addr();
        wr_regs(8'hA4, 8'hFE, 8'h20, 1'b0, 8);
        wr_regs(8'hD6, 8'hFE, 8'h20, 1'b0, 8);
        chk_cfg(rows[4]);
    endtask : test_bad_addr

    task automatic test_partial();
        wr_regs(8'hD2, 8'hFF, 8'h20, 1'b1, 4);
        chk_cfg(rows[4]);
        rd_regs(8'h00, 8'hCE);
    endtask : test_partial

    task report_and_stop();
        if (err_count == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        repeat (40) @(posedge core_clk);
        #1.3;
        test_defaults();
        test_table();
        test_bad_addr();
        test_partial();
        report_and_stop();
    end
endmodule : ccs_clock_synth_ctrl_bench
